// ---- src/bdd_pkg.sv ----
// Purpose: shared constants for the bcd adjust / decrement / divide datapath
// Assumes: 100 MHz core clock, opcode bytes delivered by the decoder
// Notes: cycle figures are whole core clocks
package bdd_pkg;

  // ****************************************
  // opcodes and reg field values
  // ****************************************
  localparam logic [7:0] OPC_FIXUP_ADD = 8'h27;
  localparam logic [7:0] OPC_FIXUP_SUB = 8'h2f;
  localparam logic [7:0] OPC_GRP_BYTE = 8'hfe;
  localparam logic [7:0] OPC_GRP_WORD = 8'hff;
  localparam logic [7:0] OPC_DEC_REG_BASE = 8'h48;
  localparam logic [7:0] OPC_MULDIV_BYTE = 8'hf6;
  localparam logic [7:0] OPC_MULDIV_WORD = 8'hf7;
  localparam logic [2:0] REG_FIELD_DEC = 3'h1;
  localparam logic [2:0] REG_FIELD_DIV = 3'h6;

  // ****************************************
  // bcd fix-up constants
  // ****************************************
  localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0f;
  localparam logic [7:0] LOW_NIBBLE_MAX = 8'h09;
  localparam logic [7:0] LOW_ADJUST = 8'h06;
  localparam logic [7:0] HIGH_LIMIT = 8'h9f;
  localparam logic [7:0] HIGH_ADJUST = 8'h60;

  // ****************************************
  // clock counts per operation
  // ****************************************
  localparam logic [5:0] CYC_FIXUP = 6'h04;
  localparam logic [5:0] CYC_DEC_REG = 6'h03;
  localparam logic [5:0] CYC_DEC_MEM = 6'h0f;
  localparam logic [5:0] CYC_DEC_MEM_W8 = 6'h13;
  localparam logic [5:0] CYC_DIVB_REG = 6'h1d;
  localparam logic [5:0] CYC_DIVB_MEM = 6'h23;
  localparam logic [5:0] CYC_DIVW_REG = 6'h26;
  localparam logic [5:0] CYC_DIVW_MEM = 6'h2c;
  localparam logic [5:0] CYC_DIVW_MEM_W8 = 6'h30;

  // ****************************************
  // flag vector bit positions (flags_in / flags_out)
  // ****************************************
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 1;
  localparam int FLAG_AUX = 2;
  localparam int FLAG_ZERO = 3;
  localparam int FLAG_SIGN = 4;
  localparam int FLAG_OVF = 5;
  localparam int DIVIDE_ERROR_VECTOR = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  typedef enum logic [2:0] {
    BDD_OP_NONE,
    BDD_OP_FIX_ADD,
    BDD_OP_FIX_SUB,
    BDD_OP_DEC,
    BDD_OP_DIV_BYTE,
    BDD_OP_DIV_WORD
  } bdd_op_type;

endpackage

// ---- src/bdd_divider.sv ----
// Purpose: restoring unsigned divider, 32 by 16 or 16 by 8
// Assumes: start is a one-cycle pulse while idle
// Notes: one quotient bit per clock; overflow is checked before iterating
`timescale 1ns/1ps
module bdd_divider (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // request
  input wire logic start_in,
  input wire logic word_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  // answer
  output logic done_out,
  output logic overflow_out,
  output logic [15:0] quotient_out,
  output logic [15:0] remainder_out
);

  logic busy_reg, busy_next;
  logic [4:0] count_reg, count_next;
  logic [16:0] rem_reg, rem_next;
  logic [31:0] dvd_reg, dvd_next;
  logic [15:0] dvs_reg, dvs_next;
  logic done_reg, done_next;
  logic ovf_reg, ovf_next;
  logic [15:0] quo_reg, quo_next;
  logic [15:0] rmd_reg, rmd_next;

  // next-state: overflow when high half of dividend is not below divisor
  always_comb begin
    logic [16:0] trial;
    trial = 17'h00000;
    busy_next = busy_reg;
    count_next = count_reg;
    rem_next = rem_reg;
    dvd_next = dvd_reg;
    dvs_next = dvs_reg;
    done_next = 1'b0;
    ovf_next = ovf_reg;
    quo_next = quo_reg;
    rmd_next = rmd_reg;
    if (start_in && !busy_reg) begin
      dvs_next = word_in ? divisor_in : {8'h00, divisor_in[7:0]};
      dvd_next = word_in ? dividend_in : {dividend_in[15:0], 16'h0000};
      rem_next = 17'h00000;
      count_next = word_in ? 5'h10 : 5'h08;
      // quotient too wide, which also catches a zero divisor
      if (word_in ? (dividend_in[31:16] >= divisor_in) : (dividend_in[15:8] >= divisor_in[7:0])) begin
        done_next = 1'b1;
        ovf_next = 1'b1;
      end else begin
        busy_next = 1'b1;
        ovf_next = 1'b0;
        // preload the high half as the running remainder
        rem_next = word_in ? {1'b0, dividend_in[31:16]} : {9'h000, dividend_in[15:8]};
        dvd_next = word_in ? {dividend_in[15:0], 16'h0000} : {dividend_in[7:0], 24'h000000};
        quo_next = 16'h0000;
      end
    end else if (busy_reg) begin
      trial = {rem_reg[15:0], dvd_reg[31]};
      dvd_next = {dvd_reg[30:0], 1'b0};
      if (trial >= {1'b0, dvs_reg}) begin
        rem_next = trial - {1'b0, dvs_reg};
        quo_next = {quo_reg[14:0], 1'b1};
      end else begin
        rem_next = trial;
        quo_next = {quo_reg[14:0], 1'b0};
      end
      count_next = count_reg - 5'h01;
      if (count_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        rmd_next = rem_next[15:0];
      end
    end
  end

  // registers only
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      count_reg <= 5'h00;
      rem_reg <= 17'h00000;
      dvd_reg <= 32'h00000000;
      dvs_reg <= 16'h0000;
      done_reg <= 1'b0;
      ovf_reg <= 1'b0;
      quo_reg <= 16'h0000;
      rmd_reg <= 16'h0000;
    end else begin
      busy_reg <= busy_next;
      count_reg <= count_next;
      rem_reg <= rem_next;
      dvd_reg <= dvd_next;
      dvs_reg <= dvs_next;
      done_reg <= done_next;
      ovf_reg <= ovf_next;
      quo_reg <= quo_next;
      rmd_reg <= rmd_next;
    end
  end

  assign done_out = done_reg;
  assign overflow_out = ovf_reg;
  assign quotient_out = quo_reg;
  assign remainder_out = rmd_reg;

endmodule

// ---- src/bdd_alu.sv ----
// Purpose: bcd fix-up, decrement and unsigned divide execution datapath
// Assumes: decoder presents opcode, reg field and operands with a start pulse
// Notes: write strobes land with done_out after the documented clocks; results and flags are registered earlier
`timescale 1ns/1ps

module bdd_alu (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // request from decoder
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [2:0] reg_field_in,
  input wire logic mem_operand_in,
  input wire logic narrow_bus_in,
  // operands
  input wire logic [15:0] accumulator_word_in,
  input wire logic [15:0] extension_word_in,
  input wire logic [15:0] operand_in,
  input wire logic [5:0] flags_in,
  // results
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output logic [15:0] accumulator_word_out,
  output logic [15:0] extension_word_out,
  output logic [15:0] operand_out,
  output logic acc_write_out,
  output logic ext_write_out,
  output logic operand_write_out,
  output logic [5:0] flags_out,
  output logic divide_error_out
);

  // ****************************************
  // helpers
  // ****************************************
  // even parity of the low byte, as the flag defines it
  function automatic logic parity8(input logic [7:0] v);
    parity8 = ~^v;
  endfunction

  // result flags common to fix-up and decrement
  function automatic logic [2:0] szp(input logic [15:0] v, input logic word);
    logic s;
    logic z;
    s = word ? v[15] : v[7];
    z = word ? (v == 16'h0000) : (v[7:0] == 8'h00);
    szp = {s, z, parity8(v[7:0])};
  endfunction

  // ****************************************
  // sequencer state
  // ****************************************
  typedef enum logic [1:0] {BDD_IDLE, BDD_WAIT, BDD_DIV} bdd_state_type;

  bdd_state_type state_reg, state_next;
  bdd_pkg::bdd_op_type op_reg, op_next;
  logic [5:0] cnt_reg, cnt_next;
  logic word_reg, word_next;
  logic [15:0] acc_reg, acc_next;
  logic [15:0] ext_reg, ext_next;
  logic [15:0] opr_reg, opr_next;
  logic [5:0] flg_reg, flg_next;
  logic done_reg, done_next;
  logic ill_reg, ill_next;
  logic accw_reg, accw_next;
  logic extw_reg, extw_next;
  logic oprw_reg, oprw_next;
  logic derr_reg, derr_next;
  logic div_start;
  logic div_done;
  logic div_ovf;
  logic [15:0] div_quo;
  logic [15:0] div_rem;
  logic [31:0] div_dividend;

  // ****************************************
  // decode and datapath
  // ****************************************
  always_comb begin
    logic [7:0] al;
    logic c;
    logic a;
    logic [15:0] dres;
    logic [2:0] f3;
    bdd_pkg::bdd_op_type dec_op;
    logic dec_word;
    logic [5:0] dec_cyc;
    al = 8'h00;
    c = 1'b0;
    a = 1'b0;
    dres = 16'h0000;
    f3 = 3'h0;
    dec_op = bdd_pkg::BDD_OP_NONE;
    dec_word = 1'b0;
    dec_cyc = bdd_pkg::CYC_FIXUP;
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    acc_next = acc_reg;
    ext_next = ext_reg;
    opr_next = opr_reg;
    flg_next = flg_reg;
    done_next = 1'b0;
    ill_next = 1'b0;
    accw_next = 1'b0;
    extw_next = 1'b0;
    oprw_next = 1'b0;
    derr_next = 1'b0;
    div_start = 1'b0;
    if (opcode_in == bdd_pkg::OPC_FIXUP_ADD) begin
      dec_op = bdd_pkg::BDD_OP_FIX_ADD;
    end else if (opcode_in == bdd_pkg::OPC_FIXUP_SUB) begin
      dec_op = bdd_pkg::BDD_OP_FIX_SUB;
    end else if ((opcode_in & 8'hf8) == bdd_pkg::OPC_DEC_REG_BASE) begin
      dec_op = bdd_pkg::BDD_OP_DEC;
      dec_word = 1'b1;
      dec_cyc = bdd_pkg::CYC_DEC_REG;
    end else if ((opcode_in == bdd_pkg::OPC_GRP_BYTE || opcode_in == bdd_pkg::OPC_GRP_WORD)
                 && reg_field_in == bdd_pkg::REG_FIELD_DEC) begin
      dec_op = bdd_pkg::BDD_OP_DEC;
      dec_word = opcode_in[0];
      dec_cyc = !mem_operand_in ? bdd_pkg::CYC_DEC_REG :
                (dec_word && narrow_bus_in) ? bdd_pkg::CYC_DEC_MEM_W8 : bdd_pkg::CYC_DEC_MEM;
    end else if (opcode_in == bdd_pkg::OPC_MULDIV_BYTE && reg_field_in == bdd_pkg::REG_FIELD_DIV) begin
      dec_op = bdd_pkg::BDD_OP_DIV_BYTE;
      dec_cyc = mem_operand_in ? bdd_pkg::CYC_DIVB_MEM : bdd_pkg::CYC_DIVB_REG;
    end else if (opcode_in == bdd_pkg::OPC_MULDIV_WORD && reg_field_in == bdd_pkg::REG_FIELD_DIV) begin
      dec_op = bdd_pkg::BDD_OP_DIV_WORD;
      dec_word = 1'b1;
      dec_cyc = !mem_operand_in ? bdd_pkg::CYC_DIVW_REG :
                narrow_bus_in ? bdd_pkg::CYC_DIVW_MEM_W8 : bdd_pkg::CYC_DIVW_MEM;
    end
    unique case (state_reg)
      BDD_IDLE: begin
        if (start_in) begin
          if (dec_op == bdd_pkg::BDD_OP_NONE) begin
            ill_next = 1'b1; // not ours: answered at once, nothing written
            done_next = 1'b1;
          end else begin
            op_next = dec_op;
            word_next = dec_word;
            cnt_next = dec_cyc - 6'h01;
            acc_next = accumulator_word_in;
            ext_next = extension_word_in;
            opr_next = operand_in;
            flg_next = flags_in;
            state_next = BDD_WAIT;
            if (dec_op == bdd_pkg::BDD_OP_FIX_ADD || dec_op == bdd_pkg::BDD_OP_FIX_SUB) begin
              al = accumulator_word_in[7:0];
              a = flags_in[bdd_pkg::FLAG_AUX];
              c = flags_in[bdd_pkg::FLAG_CARRY];
              if (((al & bdd_pkg::LOW_NIBBLE_MASK) > bdd_pkg::LOW_NIBBLE_MAX) || a) begin
                al = (dec_op == bdd_pkg::BDD_OP_FIX_ADD) ? al + bdd_pkg::LOW_ADJUST : al - bdd_pkg::LOW_ADJUST;
                a = 1'b1;
              end else begin
                a = 1'b0;
              end
              if ((al > bdd_pkg::HIGH_LIMIT) || c) begin
                al = (dec_op == bdd_pkg::BDD_OP_FIX_ADD) ? al + bdd_pkg::HIGH_ADJUST : al - bdd_pkg::HIGH_ADJUST;
                c = 1'b1;
              end else begin
                c = 1'b0;
              end
              // fix-up flags, overflow left as it was
              f3 = szp({8'h00, al}, 1'b0);
              acc_next = {accumulator_word_in[15:8], al};
              flg_next[bdd_pkg::FLAG_AUX] = a;
              flg_next[bdd_pkg::FLAG_CARRY] = c;
              flg_next[bdd_pkg::FLAG_SIGN] = f3[2];
              flg_next[bdd_pkg::FLAG_ZERO] = f3[1];
              flg_next[bdd_pkg::FLAG_PARITY] = f3[0];
            end else if (dec_op == bdd_pkg::BDD_OP_DEC) begin
              dres = dec_word ? operand_in - 16'h0001 : {operand_in[15:8], operand_in[7:0] - 8'h01};
              opr_next = dres;
              f3 = szp(dres, dec_word);
              flg_next[bdd_pkg::FLAG_SIGN] = f3[2];
              flg_next[bdd_pkg::FLAG_ZERO] = f3[1];
              flg_next[bdd_pkg::FLAG_PARITY] = f3[0];
              flg_next[bdd_pkg::FLAG_AUX] = dec_word ? (operand_in[3:0] == 4'h0) : (operand_in[3:0] == 4'h0);
              flg_next[bdd_pkg::FLAG_OVF] = dec_word ? (operand_in == 16'h8000) : (operand_in[7:0] == 8'h80);
            end else begin
              div_start = 1'b1;
              state_next = BDD_DIV;
            end
          end
        end
      end
      BDD_DIV: begin
        // divider finishes well inside the clock budget; count runs regardless
        cnt_next = cnt_reg - 6'h01;
        if (div_done) begin
          // overflow: interrupt 0, no register writes
          derr_next = div_ovf;
          if (op_reg == bdd_pkg::BDD_OP_DIV_BYTE) begin
            acc_next = {div_rem[7:0], div_quo[7:0]};
          end else begin
            acc_next = div_quo;
            ext_next = div_rem;
          end
          state_next = BDD_WAIT;
          if (div_ovf) begin
            acc_next = acc_reg;
            ext_next = ext_reg;
          end
        end
      end
      BDD_WAIT: begin
        cnt_next = cnt_reg - 6'h01;
        derr_next = derr_reg;
        if (cnt_reg <= 6'h01) begin
          state_next = BDD_IDLE;
          done_next = 1'b1;
          accw_next = (op_reg != bdd_pkg::BDD_OP_DEC) && !derr_reg;
          extw_next = (op_reg == bdd_pkg::BDD_OP_DIV_WORD) && !derr_reg;
          oprw_next = (op_reg == bdd_pkg::BDD_OP_DEC);
          derr_next = derr_reg;
        end
      end
    endcase
  end

  // error pulse is held internally until done
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= BDD_IDLE;
      op_reg <= bdd_pkg::BDD_OP_NONE;
      cnt_reg <= 6'h00;
      word_reg <= 1'b0;
      acc_reg <= 16'h0000;
      ext_reg <= 16'h0000;
      opr_reg <= 16'h0000;
      flg_reg <= bdd_pkg::FLAGS_RESET;
      done_reg <= 1'b0;
      ill_reg <= 1'b0;
      accw_reg <= 1'b0;
      extw_reg <= 1'b0;
      oprw_reg <= 1'b0;
      derr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      acc_reg <= acc_next;
      ext_reg <= ext_next;
      opr_reg <= opr_next;
      flg_reg <= flg_next;
      done_reg <= done_next;
      ill_reg <= ill_next;
      accw_reg <= accw_next;
      extw_reg <= extw_next;
      oprw_reg <= oprw_next;
      derr_reg <= (state_next == BDD_IDLE) ? 1'b0 : derr_next;
    end
  end

  // ****************************************
  // divider
  // ****************************************
  assign div_dividend = {extension_word_in, accumulator_word_in};

  bdd_divider u_div (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(div_start),
    .word_in(op_next == bdd_pkg::BDD_OP_DIV_WORD),
    .dividend_in(div_dividend),
    .divisor_in(operand_in),
    .done_out(div_done),
    .overflow_out(div_ovf),
    .quotient_out(div_quo),
    .remainder_out(div_rem)
  );

  // divide error pulse travels with done
  logic derr_out_reg;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      derr_out_reg <= 1'b0;
    end else begin
      derr_out_reg <= done_next && derr_reg && (state_reg == BDD_WAIT);
    end
  end

  assign busy_out = (state_reg != BDD_IDLE);
  assign done_out = done_reg;
  assign illegal_out = ill_reg;
  assign accumulator_word_out = acc_reg;
  assign extension_word_out = ext_reg;
  assign operand_out = opr_reg;
  assign acc_write_out = accw_reg;
  assign ext_write_out = extw_reg;
  assign operand_write_out = oprw_reg;
  assign flags_out = flg_reg;
  assign divide_error_out = derr_out_reg;

endmodule

// ---- tb/bdd_alu_assertions.sv ----
// Purpose: port-level timing and divide-error checks for the datapath
// Assumes: one clock, synchronous active high reset
// Notes: figures follow the package clock counts
`timescale 1ns/1ps
module bdd_alu_checker (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // request
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [2:0] reg_field_in,
  input wire logic mem_operand_in,
  input wire logic narrow_bus_in,
  input wire logic [5:0] flags_in,
  // answer
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic acc_write_out,
  input wire logic ext_write_out,
  input wire logic operand_write_out,
  input wire logic [5:0] flags_out,
  input wire logic divide_error_out
);
  // ****************************************
  // request sequences
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // a request only counts on an idle edge
  wire take = start_in && !busy_out;
  sequence s_fix;
    take && (opcode_in == bdd_pkg::OPC_FIXUP_ADD || opcode_in == bdd_pkg::OPC_FIXUP_SUB);
  endsequence
  sequence s_dec_reg;
    take && (opcode_in[7:3] == 5'h09);
  endsequence
  sequence s_divb;
    take && opcode_in == bdd_pkg::OPC_MULDIV_BYTE && reg_field_in == bdd_pkg::REG_FIELD_DIV;
  endsequence
  sequence s_divw;
    take && opcode_in == bdd_pkg::OPC_MULDIV_WORD && reg_field_in == bdd_pkg::REG_FIELD_DIV;
  endsequence
  sequence s_wait3;
    !done_out [*3] ##1 done_out;
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  chk_fixup_four: assert property (s_fix |-> ##1 s_wait3)
    else $error("fix-up did not finish in four clocks");
  chk_dec_reg_carry: assert property (s_dec_reg |-> ##1 !done_out [*2] ##1
    (done_out && operand_write_out && flags_out[0] == $past(flags_in[0], 3)))
    else $error("register decrement timing or carry wrong");
  chk_dec_mem_narrow: assert property (take && opcode_in == bdd_pkg::OPC_GRP_WORD &&
    reg_field_in == bdd_pkg::REG_FIELD_DEC && mem_operand_in && narrow_bus_in |-> ##19 done_out)
    else $error("narrow word memory decrement not 19 clocks");
  chk_divb_time: assert property ((s_divb and !mem_operand_in) |-> ##29 done_out)
    else $error("byte divide not 29 clocks");
  chk_divb_busy: assert property (s_divb |=> busy_out [*8])
    else $error("busy dropped during byte divide");
  chk_divw_time: assert property ((s_divw and (mem_operand_in && narrow_bus_in)) |-> ##48 done_out)
    else $error("narrow word memory divide not 48 clocks");
  // the error pulse shares its cycle with done, so both are judged at one edge
  chk_err_no_write: assert property (divide_error_out |->
    done_out && !acc_write_out && !ext_write_out)
    else $error("divide error without a write-free done");
  chk_write_no_err: assert property (done_out && (acc_write_out || ext_write_out) |-> !divide_error_out)
    else $error("divide error after a committed result");
endmodule

bind bdd_alu bdd_alu_checker u_bdd_alu_checker (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .start_in(start_in), .opcode_in(opcode_in), .reg_field_in(reg_field_in), .mem_operand_in(mem_operand_in),
  .narrow_bus_in(narrow_bus_in), .flags_in(flags_in), .busy_out(busy_out), .done_out(done_out),
  .acc_write_out(acc_write_out), .ext_write_out(ext_write_out), .operand_write_out(operand_write_out),
  .flags_out(flags_out), .divide_error_out(divide_error_out));

// ---- tb/bdd_decoder_model.sv ----
// Purpose: decoder and sequencer model that issues one request at a time
// Assumes: requests change on the falling edge only
// Notes: operands stay driven after the request, as the register file would
`timescale 1ns/1ps
module bdd_decoder_model (
  // clock and answer
  input wire logic sys_clk_in,
  input wire logic done_in,
  // request
  output logic start_out,
  output logic [7:0] opcode_out,
  output logic [2:0] reg_field_out,
  output logic mem_operand_out,
  output logic narrow_bus_out,
  output logic [15:0] acc_out,
  output logic [15:0] ext_out,
  output logic [15:0] operand_out,
  output logic [5:0] flags_out
);
  // idle request lines from time zero
  initial begin
    start_out = 1'b0;
    opcode_out = 8'h00;
    reg_field_out = 3'h0;
    mem_operand_out = 1'b0;
    narrow_bus_out = 1'b0;
    {ext_out, acc_out} = 32'h0;
    operand_out = 16'h0;
    flags_out = 6'h00;
  end

  // one-cycle start, then count clocks until done, bounded
  task automatic issue(input logic [7:0] opc, input logic [2:0] rf, input logic [1:0] mode,
    input logic [31:0] dvd, input logic [15:0] opd, input logic [5:0] flg, output int cyc);
    @(negedge sys_clk_in);
    opcode_out = opc;
    reg_field_out = rf;
    {narrow_bus_out, mem_operand_out} = mode;
    {ext_out, acc_out} = dvd;
    operand_out = opd;
    flags_out = flg;
    start_out = 1'b1;
    @(negedge sys_clk_in);
    start_out = 1'b0;
    cyc = 1;
    while (done_in !== 1'b1 && cyc < 100) begin
      @(negedge sys_clk_in);
      cyc++;
    end
  endtask
endmodule

// ---- tb/tb_bdd_alu.sv ----
// Purpose: self-checking bench for the bcd adjust / decrement / divide datapath
// Assumes: decoder model issues one request at a time
// Notes: expectations are computed here, never read back from the design
`timescale 1ns/1ps
module tb_bdd_alu;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in, mem_in, narrow_in, busy_out, done_out, illegal_out, acc_wr, ext_wr, opd_wr, div_err;
  logic [7:0] opcode_in;
  logic [2:0] rf_in;
  logic [15:0] acc_in, ext_in, opd_in, acc_out, ext_out, opd_out;
  logic [5:0] flags_in, flags_out;
  logic [9:0] e;
  int n_fail = 0;
  int comparisons = 0;
  int cyc;
  // {sub, aux, carry, byte}: both carries, aux in, carry in, no adjust
  logic [10:0] fix_tab [5] = '{11'h09a, 11'h212, 11'h510, 11'h445, 11'h40f};

  // ****************************************
  // clock, model and design
  // ****************************************
  always #5 sys_clk_in = ~sys_clk_in;
  bdd_decoder_model u_bdd_decoder_model (.sys_clk_in(sys_clk_in), .done_in(done_out), .start_out(start_in),
    .opcode_out(opcode_in), .reg_field_out(rf_in), .mem_operand_out(mem_in), .narrow_bus_out(narrow_in),
    .acc_out(acc_in), .ext_out(ext_in), .operand_out(opd_in), .flags_out(flags_in));
  bdd_alu u_bdd_alu (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .start_in(start_in), .opcode_in(opcode_in),
    .reg_field_in(rf_in), .mem_operand_in(mem_in), .narrow_bus_in(narrow_in), .accumulator_word_in(acc_in),
    .extension_word_in(ext_in), .operand_in(opd_in), .flags_in(flags_in), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out), .accumulator_word_out(acc_out),
    .extension_word_out(ext_out), .operand_out(opd_out), .acc_write_out(acc_wr), .ext_write_out(ext_wr),
    .operand_write_out(opd_wr), .flags_out(flags_out), .divide_error_out(div_err));

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // issue a request and check its clock count; a hang ends the run
  task automatic run(input logic [7:0] opc, input logic [2:0] rf, input logic [1:0] mode,
    input logic [31:0] dvd, input logic [15:0] opd, input logic [5:0] flg, input int n);
    u_bdd_decoder_model.issue(opc, rf, mode, dvd, opd, flg, cyc);
    if (cyc >= 100) begin
      n_fail++;
      $display("BAD done expected pulse seen none");
      close_out();
    end else begin
      check("clocks", n, cyc);
    end
  endtask

  // adjust reference: second test looks at the byte after the first step
  function automatic logic [9:0] fix(input logic [7:0] a, input logic cf, input logic af, input logic sub);
    logic [7:0] v;
    logic c;
    logic h;
    v = a;
    h = ((a & 8'h0f) > 8'h09) || af;
    if (h) v = sub ? v - 8'h06 : v + 8'h06;
    c = (v > 8'h9f) || cf;
    if (c) v = sub ? v - 8'h60 : v + 8'h60;
    return {c, h, v};
  endfunction

  task automatic dec_case(input logic [7:0] opc, input logic [1:0] mode, input logic [15:0] v,
    input logic cf, input int n);
    logic bt;
    logic [15:0] r;
    bt = (opc == 8'hfe);
    r = bt ? {v[15:8], v[7:0] - 8'h01} : v - 16'h0001;
    run(opc, (opc[7:3] == 5'h09) ? 3'h7 : 3'h1, mode, 32'h0, v, {5'h00, cf}, n);
    check("dec value", {1'b1, r}, {opd_wr, opd_out});
    check("dec flags", {cf, bt ? r[7:0] == 8'h00 : r == 16'h0, bt ? v[7:0] == 8'h80 : v == 16'h8000},
      {flags_out[0], flags_out[3], flags_out[5]});
  endtask

  // byte form ignores the extension word and the divisor high byte
  task automatic div_case(input logic word, input logic [1:0] mode, input logic [31:0] dvd,
    input logic [15:0] dsr, input int n);
    logic [31:0] num;
    logic [15:0] den;
    logic [31:0] q;
    logic [31:0] r;
    logic ovf;
    num = word ? dvd : {16'h0, dvd[15:0]};
    den = word ? dsr : {8'h00, dsr[7:0]};
    q = (den == 16'h0) ? 32'hffffffff : num / den;
    r = (den == 16'h0) ? 32'h0 : num % den;
    ovf = word ? (q > 32'h0000ffff) : (q > 32'h000000ff);
    run(word ? 8'hf7 : 8'hf6, 3'h6, mode, dvd, dsr, 6'h00, n);
    check("div writes", {!ovf, word && !ovf}, {acc_wr, ext_wr});
    if (!ovf) check("div result", word ? {r[15:0], q[15:0]} : {16'h0, r[7:0], q[7:0]},
      word ? {ext_out, acc_out} : {16'h0, acc_out});
    // error pulse stands in the same cycle as done
    check("div error", ovf, div_err);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 5; i++) begin
      e = fix(fix_tab[i][7:0], fix_tab[i][8], fix_tab[i][9], fix_tab[i][10]);
      run(fix_tab[i][10] ? 8'h2f : 8'h27, 3'h0, {i[0], 1'b0}, {24'h0, fix_tab[i][7:0]}, 16'h0,
        {3'h0, fix_tab[i][9], 1'b0, fix_tab[i][8]}, 4);
      check("fix", {e[9:8], e[7:0] == 8'h00, e[7], ~^e[7:0], e[7:0]}, {flags_out[0], flags_out[2],
        flags_out[3], flags_out[4], flags_out[1], acc_out[7:0]});
    end
    $display("test fixup done");
    dec_case(8'hfe, 2'b00, 16'h1200, 1'b1, 3);
    dec_case(8'hfe, 2'b11, 16'h3480, 1'b0, 15);
    dec_case(8'hff, 2'b01, 16'h0001, 1'b1, 15);
    dec_case(8'hff, 2'b11, 16'h8000, 1'b0, 19);
    dec_case(8'h48, 2'b00, 16'h0000, 1'b1, 3);
    dec_case(8'h4f, 2'b00, 16'h8000, 1'b0, 3);
    $display("test decrement done");
    div_case(1'b0, 2'b00, 32'h1234_0061, 16'hab06, 29);
    div_case(1'b0, 2'b11, 32'h0000_00ff, 16'h0010, 35);
    div_case(1'b0, 2'b00, 32'h0000_0400, 16'h0002, 29);
    div_case(1'b1, 2'b00, 32'h000d_5c50, 16'he000, 38);
    div_case(1'b1, 2'b01, 32'hfffe_ffff, 16'hffff, 44);
    div_case(1'b1, 2'b11, 32'h0000_fffe, 16'hffff, 48);
    div_case(1'b1, 2'b00, 32'h0000_0005, 16'h0000, 38);
    $display("test divide done");
    run(8'h90, 3'h0, 2'b00, 32'h0, 16'h0, 6'h00, 1);
    check("illegal", 2'b10, {illegal_out, acc_wr});
    $display("test illegal done");
    close_out();
  end
endmodule
